// ---- logic/dac_front_params.svh ----
// constants of the interpolating dac front end
`ifndef DAC_FRONT_PARAMS_SVH
`define DAC_FRONT_PARAMS_SVH
`define ADR_CTRL        4'h0
`define ADR_DITHER      4'h1
`define ADR_STATUS      4'h2
`define ADR_SAMPLE      4'h3
`define CTRL_FMT_BIT    0
`define CTRL_MODE_LSB   1
`define CTRL_SHUF_EN    3
`define CTRL_SHUF_LSB   4
`define CTRL_NS_EN      6
`define CTRL_PLL_DIS    7
`define CTRL_RESET      8'h00
`define DITHER_RESET    4'h0
`define LFSR_SEED       16'hace1
`define LOCK_TIME_NS    2000
`define CLK_PERIOD_NS   20
`define LOCK_CYCLES     ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- logic/dac_front_pkg.sv ----
// types of the interpolating dac front end
package dac_front_pkg;
  typedef enum logic [1:0] {
    MODE_X1      = 2'h0,
    MODE_X2_SLOW = 2'h1,
    MODE_X2_FAST = 2'h2,
    MODE_X4      = 2'h3
  } interp_mode_t;
  typedef enum logic [1:0] {
    SHUF_4  = 2'h0,
    SHUF_8  = 2'h1,
    SHUF_16 = 2'h2
  } shuf_period_t;
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_WAIT = 3'b010,
    LK_DONE = 3'b100
  } lock_state_t;
endpackage : dac_front_pkg

// ---- logic/dac_front.sv ----
// interpolating dac front end with wishbone control
`timescale 1ns/1ps
`include "dac_front_params.svh"
module dac_front #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // sample input
  input  wire logic [15:0]               sample_data,
  input  wire logic                      sample_strobe,
  input  wire logic                      fmt_twos,
  // clock multiplier
  input  wire logic                      pll_phase_ok,
  output logic                           pll_lock,
  output logic                           clk_bypass,
  // converter core
  output logic [11:0]                    core_data,
  output logic                           core_update,
  output logic [3:0]                     seg_rotate,
  output logic                           sample_take
);
  import dac_front_pkg::*;

  logic [7:0]         ctrl_ff;
  logic [3:0]         dither_ff;
  logic [1:0]         fmt_sync_ff;
  logic [1:0]         strobe_sync_ff;
  logic [1:0]         phase_sync_ff;
  logic               strobe_old_ff;
  logic [15:0]        s0_sync_ff;
  logic [15:0]        s1_sync_ff;
  logic [15:0]        cur_ff;
  logic [15:0]        prev_ff;
  logic [1:0]         phase_ff;
  logic               step_ff;
  logic               take_ff;
  logic [15:0]        lfsr_ff;
  logic [15:0]        dith_old_ff;
  logic [17:0]        err1_ff;
  logic [17:0]        err2_ff;
  logic [3:0]         upd_cnt_ff;
  logic [1:0]         rot_ff;
  lock_state_t        lk_ff;
  logic [15:0]        lk_cnt_ff;
  interp_mode_t       mode;
  shuf_period_t       shuf;
  logic               strobe_rise;
  logic [15:0]        in_word;
  logic [17:0]        interp;
  logic [17:0]        dith_hp;
  logic [17:0]        shaped;
  logic [11:0]        quant;
  logic               upd_now;
  logic [3:0]         shuf_max;
  logic [1:0]         rot_step;

  assign mode = interp_mode_t'(ctrl_ff[`CTRL_MODE_LSB +: 2]);
  assign shuf = shuf_period_t'(ctrl_ff[`CTRL_SHUF_LSB +: 2]);

  // bus access, one wait state answer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      ctrl_ff   <= `CTRL_RESET;
      dither_ff <= `DITHER_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0]) begin
          if (wb_adr_i == `ADR_CTRL) begin
            ctrl_ff <= wb_dat_i[7:0];
          end
          if (wb_adr_i == `ADR_DITHER) begin
            dither_ff <= wb_dat_i[3:0];
          end
        end
        unique case (wb_adr_i)
          `ADR_CTRL:   wb_dat_o <= {24'h0, ctrl_ff};
          `ADR_DITHER: wb_dat_o <= {28'h0, dither_ff};
          `ADR_STATUS: wb_dat_o <= {28'h0, rot_ff, clk_bypass, pll_lock};
          `ADR_SAMPLE: wb_dat_o <= {16'h0, cur_ff};
          default:     wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fmt_sync_ff    <= 2'h0;
      strobe_sync_ff <= 2'h0;
      phase_sync_ff  <= 2'h0;
      s0_sync_ff     <= 16'h0;
      s1_sync_ff     <= 16'h0;
      strobe_old_ff  <= 1'b0;
    end else begin
      fmt_sync_ff    <= {fmt_sync_ff[0], fmt_twos};
      strobe_sync_ff <= {strobe_sync_ff[0], sample_strobe};
      phase_sync_ff  <= {phase_sync_ff[0], pll_phase_ok};
      s0_sync_ff     <= sample_data;
      s1_sync_ff     <= s0_sync_ff;
      strobe_old_ff  <= strobe_sync_ff[1];
    end
  end

  assign strobe_rise = strobe_sync_ff[1] && !strobe_old_ff;
  // twos complement made offset binary by msb flip
  assign in_word = {s1_sync_ff[15] ^ fmt_sync_ff[1], s1_sync_ff[14:0]};

  // capture one word per input period
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cur_ff  <= 16'h8000;
      prev_ff <= 16'h8000;
      take_ff <= 1'b0;
    end else begin
      take_ff <= strobe_rise;
      if (strobe_rise) begin
        prev_ff <= cur_ff;
        cur_ff  <= in_word;
      end
    end
  end

  // update phase within an input period; core update enable per mode
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase_ff <= 2'h0;
      step_ff  <= 1'b0;
    end else if (strobe_rise) begin
      phase_ff <= 2'h0;
      step_ff  <= 1'b0;
    end else begin
      // stops at the last phase so one period never repeats
      phase_ff <= (phase_ff == 2'h3) ? phase_ff : phase_ff + 2'h1;
      step_ff  <= (phase_ff != 2'h3);
    end
  end

  always_comb begin
    upd_now = 1'b0;
    unique case (mode)
      MODE_X1:      upd_now = take_ff;
      MODE_X2_SLOW: upd_now = take_ff || (step_ff && (phase_ff == 2'h1));
      MODE_X2_FAST: upd_now = take_ff || (step_ff && (phase_ff == 2'h1));
      MODE_X4:      upd_now = take_ff || (step_ff && (phase_ff != 2'h0));
    endcase
  end

  // linear interpolation between samples, wider step in fast x2
  always_comb begin
    interp = {2'b00, prev_ff};
    unique case (mode)
      MODE_X1:      interp = {2'b00, cur_ff};
      MODE_X2_SLOW: interp = (phase_ff[0] ? ({2'b00, prev_ff} + {2'b00, cur_ff}) >> 1 : {2'b00, prev_ff});
      MODE_X2_FAST: interp = (phase_ff[0] ? ({2'b00, cur_ff} + {2'b00, cur_ff}) >> 1 : {2'b00, prev_ff});
      MODE_X4:      interp = ({2'b00, prev_ff} * (3'd4 - {1'b0, phase_ff}) + {2'b00, cur_ff} * {1'b0, phase_ff}) >> 2;
    endcase
  end

  // lfsr dither, first difference makes it highpass
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lfsr_ff     <= `LFSR_SEED;
      dith_old_ff <= 16'h0;
    end else if (upd_now) begin
      lfsr_ff     <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      dith_old_ff <= lfsr_ff & ((16'h1 << dither_ff) - 16'h1);
    end
  end
  assign dith_hp = {2'b00, lfsr_ff & ((16'h1 << dither_ff) - 16'h1)} - {2'b00, dith_old_ff};

  // second order error feedback: y = x + 2e1 - e2
  assign shaped = ctrl_ff[`CTRL_NS_EN]
                ? interp + dith_hp + (err1_ff << 1) - err2_ff
                : interp + dith_hp;
  assign quant = shaped[17] ? 12'h000 : (shaped[16] ? 12'hfff : shaped[15:4]);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      err1_ff     <= 18'h0;
      err2_ff     <= 18'h0;
      core_data   <= 12'h800;
      core_update <= 1'b0;
      sample_take <= 1'b0;
    end else begin
      core_update <= upd_now;
      sample_take <= take_ff;
      if (upd_now) begin
        core_data <= quant;
        err2_ff   <= err1_ff;
        err1_ff   <= ctrl_ff[`CTRL_NS_EN] ? {14'h0, 4'h0} - {14'h0, shaped[3:0]} : 18'h0;
      end
    end
  end

  // segment shuffle counter and rotation
  always_comb begin
    shuf_max = 4'h3;
    unique case (shuf)
      SHUF_4:  shuf_max = 4'h3;
      SHUF_8:  shuf_max = 4'h7;
      SHUF_16: shuf_max = 4'hf;
      default: shuf_max = 4'hf;
    endcase
  end
  // nonzero step so every shuffle point moves the quarter
  assign rot_step = (lfsr_ff[1:0] == 2'h0) ? 2'h1 : lfsr_ff[1:0];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      upd_cnt_ff <= 4'h0;
      rot_ff     <= 2'h0;
      seg_rotate <= 4'h1;
    end else begin
      if (ctrl_ff[`CTRL_SHUF_EN] && upd_now) begin
        if (upd_cnt_ff >= shuf_max) begin
          upd_cnt_ff <= 4'h0;
          rot_ff     <= rot_ff ^ rot_step;
        end else begin
          upd_cnt_ff <= upd_cnt_ff + 4'h1;
        end
      end
      // one-hot start quarter only; cell count from core_data untouched
      seg_rotate <= 4'h1 << rot_ff;
    end
  end

  // clock multiplier lock supervision
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lk_ff      <= LK_IDLE;
      lk_cnt_ff  <= 16'h0;
      pll_lock   <= 1'b0;
      clk_bypass <= 1'b0;
    end else begin
      clk_bypass <= ctrl_ff[`CTRL_PLL_DIS];
      unique case (lk_ff)
        LK_IDLE: begin
          lk_cnt_ff <= 16'h0;
          if (phase_sync_ff[1] && !ctrl_ff[`CTRL_PLL_DIS]) begin
            lk_ff <= LK_WAIT;
          end
        end
        LK_WAIT: begin
          lk_cnt_ff <= lk_cnt_ff + 16'h1;
          if (!phase_sync_ff[1] || ctrl_ff[`CTRL_PLL_DIS]) begin
            lk_ff <= LK_IDLE;
          end else if (lk_cnt_ff >= 16'(LOCK_CYCLES - 1)) begin
            lk_ff <= LK_DONE;
          end
        end
        LK_DONE: begin
          if (!phase_sync_ff[1] || ctrl_ff[`CTRL_PLL_DIS]) begin
            lk_ff <= LK_IDLE;
          end
        end
      endcase
      pll_lock <= (lk_ff == LK_DONE) && phase_sync_ff[1] && !ctrl_ff[`CTRL_PLL_DIS];
    end
  end

  // assertions
  sequence phase_lost_s;
    !phase_sync_ff[1];
  endsequence

  lock_drops_a: assert property (@(posedge core_clk) disable iff (!resetn)
    phase_lost_s |=> !pll_lock) else $error("lock held after phase loss");
  lock_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(pll_lock) |-> $past(lk_ff) == LK_DONE) else $error("lock rose without wait");
  bypass_fol_a: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_bypass |-> !pll_lock) else $error("lock while bypassed");
  take_upd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    strobe_rise |=> ##1 core_update && sample_take) else $error("sample not taken");
  x1_only_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (mode == MODE_X1) && core_update |-> $past(take_ff)) else $error("extra update in x1");
  msb_fmt_a: assert property (@(posedge core_clk) disable iff (!resetn)
    strobe_rise |=> cur_ff[15] == ($past(s1_sync_ff[15]) ^ $past(fmt_sync_ff[1]))) else $error("msb format");
  rot_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !ctrl_ff[`CTRL_SHUF_EN] |=> $stable(rot_ff)) else $error("shuffle while off");
  seg_onehot_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $onehot(seg_rotate)) else $error("segment select not one-hot");
  ns_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !ctrl_ff[`CTRL_NS_EN] && upd_now |=> err1_ff == 18'h0) else $error("shaping error when off");
  dith_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    dither_ff == 4'h0 |-> dith_hp == 18'h0 || dith_old_ff != 16'h0) else $error("dither at zero amplitude");

  // per-sample update bursts
  sequence x4_take_s;
    (mode == MODE_X4) && take_ff;
  endsequence
  sequence x2_take_s;
    ((mode == MODE_X2_SLOW) || (mode == MODE_X2_FAST)) && take_ff;
  endsequence

  x4_burst_a: assert property (@(posedge core_clk) disable iff (!resetn)
    x4_take_s |=> upd_now [*3] ##1 !upd_now) else $error("x4 burst not four updates");
  x2_pair_a: assert property (@(posedge core_clk) disable iff (!resetn)
    x2_take_s |=> upd_now ##1 !upd_now [*2]) else $error("x2 burst not two updates");
  // shuffle point and output hold
  rot_move_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ctrl_ff[`CTRL_SHUF_EN] && upd_now && (upd_cnt_ff >= shuf_max) |=> rot_ff != $past(rot_ff))
    else $error("shuffle point kept ordering");
  take_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    sample_take |=> !sample_take) else $error("sample take longer than one cycle");
  take_upd_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
    sample_take |-> core_update) else $error("capture without core update");
  core_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !core_update |-> $stable(core_data)) else $error("core code moved without update");
endmodule : dac_front

// ---- bench/sample_src.sv ----
// digital sample source model for the parallel input
`timescale 1ns/1ps
module sample_src (
  // clock and request
  input  wire logic        core_clk,
  input  wire logic        send,
  input  wire logic [15:0] word,
  // parallel link
  output logic      [15:0] sample_data,
  output logic             sample_strobe
);
  logic [2:0] ph_ff;
  initial begin
    ph_ff = 3'h0;
    sample_data = 16'h0;
    sample_strobe = 1'b0;
  end
  always @(posedge core_clk) begin
    if (ph_ff != 3'h0 || send)
      ph_ff <= ph_ff + 3'h1;
    if (send && ph_ff == 3'h0)
      sample_data <= word;
    if (ph_ff == 3'h1)
      sample_strobe <= 1'b1;
    if (ph_ff == 3'h6) begin
      sample_strobe <= 1'b0;
      sample_data <= ~sample_data;
    end
  end
endmodule : sample_src

// ---- bench/tb_top.sv ----
// self-checking bench of the dac front end
`timescale 1ns/1ps
module tb_top;
  import dac_front_pkg::*;
  logic        clk, rstn, cyc, stb, we, fmt, pok, send, ack, strb, lock, byp, upd, take;
  logic        chk_data, cnt_on, shuf_on, armed;
  logic [3:0]  adr, sel, rot, last_rot;
  logic [31:0] dat, rdat;
  logic [15:0] word, sdat, lfsr;
  logic [11:0] code;
  logic [63:0] rd_note;
  logic [63:0] exp_rd[$];
  logic [11:0] exp_core[$];
  int          n_mismatch, n_checks, cyc_cnt, upd_cnt, exp_upd, rcnt, shuf_p;
  interp_mode_t modes[4] = '{MODE_X1, MODE_X2_SLOW, MODE_X2_FAST, MODE_X4};
  int          ups[4] = '{1, 2, 2, 4};
  always #10 clk = ~clk;
  dac_front #(.LOCK_CYCLES(4)) dac_front_i (.core_clk(clk), .resetn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sample_data(sdat), .sample_strobe(strb), .fmt_twos(fmt), .pll_phase_ok(pok),
    .pll_lock(lock), .clk_bypass(byp), .core_data(code), .core_update(upd), .seg_rotate(rot),
    .sample_take(take));
  sample_src sample_src_i (.core_clk(clk), .send(send), .word(word), .sample_data(sdat),
    .sample_strobe(strb));
  function automatic logic [15:0] nxt_rnd(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt_rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_rd.push_back({m, e});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  task automatic put(input logic [15:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : put
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // watches outputs, compares with the oldest note
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      n_mismatch++;
      give_verdict();
    end
    if (ack === 1'b1 && !we) begin
      rd_note = exp_rd.pop_front();
      chk("read data", rd_note[31:0], rdat & rd_note[63:32]);
    end
    if (take === 1'b1) begin
      if (chk_data) chk("core code", exp_core.pop_front(), code);
      if (cnt_on) chk("updates per sample", exp_upd, upd_cnt);
      upd_cnt = 0;
    end
    if (upd === 1'b1) upd_cnt++;
    if (shuf_on) begin
      chk("rotation one hot", 32'h1, $onehot(rot));
      if (rot !== last_rot) begin
        if (armed) chk("updates per rotation", shuf_p, rcnt);
        armed = 1'b1;
        rcnt = 0;
      end
      if (upd === 1'b1) rcnt++;
    end else
      armed = 1'b0;
    last_rot = rot;
  end
  initial begin
    {clk, rstn, cyc, stb, we, fmt, pok, send, chk_data, cnt_on, shuf_on, armed} = '0;
    {adr, sel, dat, word} = '0;
    lfsr = 16'h68b3;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk("lock at reset", 32'h0, lock);
    rd(4'h0, 32'h0, 32'hff);
    bus(1'b1, 4'h1, 32'h5, 4'he);
    rd(4'h1, 32'h0, 32'hf);
    rd(4'h9, 32'h0, 32'hffffffff);
    pok <= 1'b1;
    repeat (4) @(posedge clk);
    chk("lock early", 32'h0, lock);
    for (int i = 0; i < 50 && lock !== 1'b1; i++) @(posedge clk);
    chk("lock", 32'h1, lock);
    rd(4'h2, 32'h1, 32'h3);
    bus(1'b1, 4'h0, 32'h80, 4'hf);
    repeat (2) @(posedge clk);
    chk("bypass", 32'h1, byp);
    rd(4'h2, 32'h2, 32'h3);
    bus(1'b1, 4'h0, 32'h00, 4'hf);
    for (int i = 0; i < 50 && lock !== 1'b1; i++) @(posedge clk);
    chk("relock", 32'h1, lock);
    pok <= 1'b0;
    repeat (20) @(posedge clk);
    chk("lock lost", 32'h0, lock);
    $display("test registers and lock done");
    bus(1'b1, 4'h0, 32'h08, 4'hf);
    shuf_p = 4;
    shuf_on = 1'b1;
    chk_data = 1'b1;
    for (int f = 0; f < 2; f++) begin
      fmt <= f[0];
      repeat (4) @(posedge clk);
      for (int k = 0; k < 6; k++) begin
        lfsr = nxt_rnd(lfsr);
        exp_core.push_back(lfsr[15:4] ^ {f[0], 11'h0});
        put(lfsr);
      end
      rd(4'h3, {16'h0, lfsr ^ {f[0], 15'h0}}, 32'hffff);
    end
    chk_data = 1'b0;
    shuf_on = 1'b0;
    $display("test sample formats done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 4'h0, {29'h0, modes[m], 1'b0}, 4'hf);
      exp_upd = ups[m];
      put(lfsr);
      cnt_on = 1'b1;
      repeat (3) put(nxt_rnd(lfsr));
      cnt_on = 1'b0;
    end
    $display("test interpolation modes done");
    for (int p = 1; p < 3; p++) begin
      bus(1'b1, 4'h0, {26'h0, p[1:0], 4'he}, 4'hf);
      shuf_p = 4 << p;
      shuf_on = 1'b1;
      for (int k = 0; k < 20; k++) begin
        lfsr = nxt_rnd(lfsr);
        put(lfsr);
      end
      shuf_on = 1'b0;
    end
    $display("test shuffle periods done");
    bus(1'b1, 4'h1, 32'h4, 4'hf);
    bus(1'b1, 4'h0, 32'h46, 4'hf);
    rd(4'h1, 32'h4, 32'hf);
    rd(4'h0, 32'h46, 32'hff);
    repeat (4) put(nxt_rnd(lfsr));
    $display("test dither and shaping done");
    give_verdict();
  end
endmodule : tb_top
